// ===== lcm_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.svh"

// Contract
// - Step with fault enable clear: drop triggering edge, restart reference acquisition.
// - Step with fault enable set: also reset reference monitor, revalidate first.
// - Manual profile field bits 6:4 picks profile 0..5; codes 6, 7 unused.
// - Mode 0: automatically choose valid profile of highest priority.
// - Auto with no qualifying profile: holdover if history exists, else freerun.
// - Auto priority tie: lowest numbered profile wins.
// - Mode 1: manual profile until invalid, then automatic priority selection.
// - Mode 2: manual profile until invalid, then holdover.
// - Mode 3: no autonomous selection; software directs profile and state.
// - Force holdover bit 1 puts loop in holdover unless force freerun bit 0 is set; clearing restores operation.
// - Forced holdover without history uses freerun tuning word.
// - Force freerun bit 0 puts loop in freerun.
module lcm_mode_ctrl #(
  parameter int ADDR_W = 16,
  parameter int NPROF  = 6,
  parameter int PRIO_W = 3
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPROF-1:0]  profile_valid,
  input  wire logic              history_avail,
  input  wire logic              ref_validated,
  input  wire logic              phase_step,
  output logic [1:0]             loop_state,
  output logic [2:0]             active_profile,
  output logic                   use_freerun_tw,
  output logic                   discard_edge,
  output logic                   restart_acq,
  output logic                   refmon_reset
);

  localparam int PRIO_BITS = NPROF * PRIO_W;

  // ----------------------------------------------------------------
  // Registers and sampled inputs
  // ----------------------------------------------------------------
  logic [`LCM_MODE_W-1:0] mode_q;
  logic [PRIO_BITS-1:0]   prio_q;
  logic [4:0]             swctl_q;
  logic [NPROF-1:0]       valid_q;
  logic                   hist_q;
  logic                   refok_q;
  logic                   step_q;
  logic                   reval_q;
  logic                   discard_q;
  logic                   restart_q;
  logic                   refrst_q;
  lcm_pkg::lcm_state_t    state_q;
  lcm_pkg::lcm_state_t    state_d;
  logic [2:0]             prof_q;
  logic [2:0]             prof_d;
  logic                   ftw_q;

  logic                   ffree;
  logic                   fhold;
  logic                   step_flt;
  logic [1:0]             smode;
  logic [2:0]             mprof;
  logic                   man_ok;
  logic                   found;
  logic [2:0]             best;
  logic                   wr_en;
  logic                   rd_hit;
  logic [13:0]            widx;

  assign ffree    = mode_q[`LCM_FFREE];
  assign fhold    = mode_q[`LCM_FHOLD];
  assign step_flt = mode_q[`LCM_STEP_FLT];
  assign smode    = mode_q[`LCM_SMODE_HI:`LCM_SMODE_LO];
  assign mprof    = mode_q[`LCM_MPROF_HI:`LCM_MPROF_LO];

  // ----------------------------------------------------------------
  // Profile helpers
  // ----------------------------------------------------------------
  // Codes past the last profile never count as valid
  function automatic logic prof_valid(input logic [NPROF-1:0] v, input logic [2:0] p);
    prof_valid = (int'(p) < NPROF) ? v[p] : 1'b0;
  endfunction

  // Smaller priority value wins; strict compare keeps the lowest index on a tie
  function automatic logic [3:0] pick_best(input logic [NPROF-1:0] v,
                                           input logic [PRIO_BITS-1:0] pr);
    logic [PRIO_W-1:0] bp;
    logic              f;
    logic [2:0]        bi;
    bp = '0;
    f  = 1'b0;
    bi = 3'h0;
    for (int i = 0; i < NPROF; i++) begin
      if (v[i] && (!f || pr[i*PRIO_W +: PRIO_W] < bp)) begin
        f  = 1'b1;
        bp = pr[i*PRIO_W +: PRIO_W];
        bi = 3'(i);
      end
    end
    pick_best = {f, bi};
  endfunction

  assign man_ok        = prof_valid(valid_q, mprof);
  assign {found, best} = pick_best(valid_q, prio_q);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign widx    = paddr[15:2];
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign rd_hit  = (widx == `LCM_IDX_MODE) || (widx == `LCM_IDX_PRIO) ||
                   (widx == `LCM_IDX_SWCTL) || (widx == `LCM_IDX_STAT);
  assign pslverr = psel && penable && (!rd_hit || paddr[1:0] != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= `LCM_MODE_RST;
      prio_q  <= `LCM_PRIO_RST;
      swctl_q <= `LCM_SWCTL_RST;
    end else if (wr_en && paddr[1:0] == 2'h0) begin
      unique case (widx)
        `LCM_IDX_MODE:  mode_q  <= pwdata[`LCM_MODE_W-1:0];
        `LCM_IDX_PRIO:  prio_q  <= pwdata[PRIO_BITS-1:0];
        `LCM_IDX_SWCTL: swctl_q <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite && paddr[1:0] == 2'h0) begin
      unique case (widx)
        `LCM_IDX_MODE:  prdata[`LCM_MODE_W-1:0] = mode_q;
        `LCM_IDX_PRIO:  prdata[PRIO_BITS-1:0]   = prio_q;
        `LCM_IDX_SWCTL: prdata[4:0]             = swctl_q;
        `LCM_IDX_STAT: begin
          prdata[`LCM_ST_ST_LO +: 2]         = state_q;
          prdata[`LCM_ST_PR_LO +: 3]         = prof_q;
          prdata[`LCM_ST_FTW]                = ftw_q;
          prdata[`LCM_ST_REVAL]              = reval_q;
          prdata[`LCM_ST_HIST]               = hist_q;
          prdata[`LCM_ST_VAL_LO +: NPROF]    = valid_q;
        end
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= '0;
      hist_q  <= 1'b0;
      refok_q <= 1'b0;
      step_q  <= 1'b0;
    end else begin
      valid_q <= profile_valid;
      hist_q  <= history_avail;
      refok_q <= ref_validated;
      step_q  <= phase_step;
    end
  end

  // ----------------------------------------------------------------
  // Phase step handling
  // ----------------------------------------------------------------
  // A step always drops its edge; with the fault enable set the restart
  // waits until the reference monitor has revalidated the input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_q <= 1'b0;
      restart_q <= 1'b0;
      refrst_q  <= 1'b0;
      reval_q   <= 1'b0;
    end else begin
      discard_q <= step_q;
      refrst_q  <= step_q && step_flt;
      restart_q <= (step_q && !step_flt) ||
                   (!step_q && reval_q && refok_q);
      // New step wins over completion of a pending revalidation
      if (step_q && step_flt) begin
        reval_q <= 1'b1;
      end else if (refok_q) begin
        reval_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Loop state selection
  // ----------------------------------------------------------------
  // Fallback is evaluated every cycle, so a manual profile that becomes
  // valid again is taken back without software action.
  always_comb begin
    state_d = lcm_pkg::LCM_ST_FREERUN;
    prof_d  = prof_q;
    if (ffree) begin
      state_d = lcm_pkg::LCM_ST_FREERUN;
    end else if (fhold) begin
      state_d = lcm_pkg::LCM_ST_HOLDOVER;
    end else begin
      unique case (smode)
        `LCM_SEL_AUTO: begin
          if (found) begin
            state_d = lcm_pkg::LCM_ST_ACTIVE;
            prof_d  = best;
          end else begin
            state_d = hist_q ? lcm_pkg::LCM_ST_HOLDOVER : lcm_pkg::LCM_ST_FREERUN;
          end
        end
        `LCM_SEL_MAN_AUT: begin
          if (man_ok) begin
            state_d = lcm_pkg::LCM_ST_ACTIVE;
            prof_d  = mprof;
          end else if (found) begin
            state_d = lcm_pkg::LCM_ST_ACTIVE;
            prof_d  = best;
          end else begin
            state_d = hist_q ? lcm_pkg::LCM_ST_HOLDOVER : lcm_pkg::LCM_ST_FREERUN;
          end
        end
        `LCM_SEL_MAN_HLD: begin
          if (man_ok) begin
            state_d = lcm_pkg::LCM_ST_ACTIVE;
            prof_d  = mprof;
          end else begin
            state_d = lcm_pkg::LCM_ST_HOLDOVER;
          end
        end
        `LCM_SEL_USER: begin
          prof_d = swctl_q[`LCM_SWPR_HI:`LCM_SWPR_LO];
          unique case (swctl_q[`LCM_SWST_HI:`LCM_SWST_LO])
            2'h1:    state_d = lcm_pkg::LCM_ST_HOLDOVER;
            2'h2:    state_d = lcm_pkg::LCM_ST_ACTIVE;
            default: state_d = lcm_pkg::LCM_ST_FREERUN;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lcm_pkg::LCM_ST_FREERUN;
      prof_q  <= 3'h0;
    end else begin
      state_q <= state_d;
      prof_q  <= prof_d;
    end
  end

  // Holdover without history falls back to the freerun word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ftw_q <= 1'b1;
    end else begin
      ftw_q <= (state_d != lcm_pkg::LCM_ST_HOLDOVER) || !hist_q;
    end
  end

  assign loop_state     = state_q;
  assign active_profile = prof_q;
  assign use_freerun_tw = ftw_q;
  assign discard_edge   = discard_q;
  assign restart_acq    = restart_q;
  assign refmon_reset   = refrst_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_step_discard;
    phase_step |-> ##2 discard_edge;
  endproperty
  a_step_discard: assert property (p_step_discard)
    else $error("step did not discard edge");

  property p_step_restart;
    phase_step && !step_flt ##1 !step_flt |=> restart_acq && !refmon_reset;
  endproperty
  a_step_restart: assert property (p_step_restart)
    else $error("step without fault enable did not restart");

  property p_step_refrst;
    phase_step ##1 step_flt |=> refmon_reset && reval_q && !restart_acq;
  endproperty
  a_step_refrst: assert property (p_step_refrst)
    else $error("step with fault enable mishandled");

  property p_reval_done;
    reval_q && refok_q && !step_q |=> restart_acq && !reval_q;
  endproperty
  a_reval_done: assert property (p_reval_done)
    else $error("revalidation did not restart acquisition");

  property p_auto_best;
    !ffree && !fhold && smode == `LCM_SEL_AUTO && found
      |=> loop_state == lcm_pkg::LCM_ST_ACTIVE && active_profile == $past(best);
  endproperty
  a_auto_best: assert property (p_auto_best)
    else $error("auto mode did not pick best profile");

  property p_auto_none;
    !ffree && !fhold && smode == `LCM_SEL_AUTO && !found
      |=> loop_state == ($past(hist_q) ? lcm_pkg::LCM_ST_HOLDOVER : lcm_pkg::LCM_ST_FREERUN);
  endproperty
  a_auto_none: assert property (p_auto_none)
    else $error("auto fallback state wrong");

  property p_tie_low;
    !ffree && !fhold && smode == `LCM_SEL_AUTO && valid_q[0] && valid_q[1] &&
      prio_q[0 +: PRIO_W] == prio_q[PRIO_W +: PRIO_W] |=> active_profile != 3'h1;
  endproperty
  a_tie_low: assert property (p_tie_low)
    else $error("tie not resolved to lower profile");

  property p_man_fallback;
    !ffree && !fhold && smode == `LCM_SEL_MAN_AUT && !man_ok && found
      |=> active_profile == $past(best);
  endproperty
  a_man_fallback: assert property (p_man_fallback)
    else $error("manual mode did not fall back to auto");

  property p_man_hold;
    !ffree && !fhold && smode == `LCM_SEL_MAN_HLD && !man_ok
      |=> loop_state == lcm_pkg::LCM_ST_HOLDOVER;
  endproperty
  a_man_hold: assert property (p_man_hold)
    else $error("manual mode did not fall back to holdover");

  property p_force_hold;
    fhold && !ffree |=> loop_state == lcm_pkg::LCM_ST_HOLDOVER &&
      use_freerun_tw == !$past(hist_q);
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("forced holdover wrong");

  property p_force_free;
    ffree |=> loop_state == lcm_pkg::LCM_ST_FREERUN && use_freerun_tw;
  endproperty
  a_force_free: assert property (p_force_free)
    else $error("forced freerun wrong");

endmodule
`default_nettype wire

// ===== lcm_regs.svh
`ifndef LCM_REGS_SVH
`define LCM_REGS_SVH

// Register word indices; byte address is four times the index
`define LCM_IDX_MODE    14'h2205
`define LCM_IDX_PRIO    14'h2280
`define LCM_IDX_SWCTL   14'h2281
`define LCM_IDX_STAT    14'h2282

// Mode register fields
`define LCM_STEP_FLT    7
`define LCM_MPROF_HI    6
`define LCM_MPROF_LO    4
`define LCM_SMODE_HI    3
`define LCM_SMODE_LO    2
`define LCM_FHOLD       1
`define LCM_FFREE       0
`define LCM_MODE_RST    8'h00
`define LCM_MODE_W      8

// Selection modes
`define LCM_SEL_AUTO    2'h0
`define LCM_SEL_MAN_AUT 2'h1
`define LCM_SEL_MAN_HLD 2'h2
`define LCM_SEL_USER    2'h3

// Own registers
`define LCM_PRIO_RST    18'h00000
`define LCM_SWCTL_RST   5'h00
`define LCM_SWST_HI     1
`define LCM_SWST_LO     0
`define LCM_SWPR_HI     4
`define LCM_SWPR_LO     2

// Status register fields
`define LCM_ST_ST_LO    0
`define LCM_ST_PR_LO    2
`define LCM_ST_FTW      5
`define LCM_ST_REVAL    6
`define LCM_ST_HIST     7
`define LCM_ST_VAL_LO   8

`endif

// ===== lcm_pkg.sv
`default_nettype none
package lcm_pkg;

  typedef enum logic [1:0] {
    LCM_ST_FREERUN  = 2'b00,
    LCM_ST_HOLDOVER = 2'b01,
    LCM_ST_ACTIVE   = 2'b10
  } lcm_state_t;

endpackage
`default_nettype wire

// ===== lcm_mode_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.svh"
module lcm_mode_ctrl_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [15:0] A_MODE = {`LCM_IDX_MODE, 2'h0};
  localparam logic [15:0] A_PRIO = {`LCM_IDX_PRIO, 2'h0};
  localparam logic [15:0] A_SW   = {`LCM_IDX_SWCTL, 2'h0};
  localparam logic [15:0] A_ST   = {`LCM_IDX_STAT, 2'h0};
  localparam logic [1:0]  FR     = lcm_pkg::LCM_ST_FREERUN;
  localparam logic [1:0]  HO     = lcm_pkg::LCM_ST_HOLDOVER;
  localparam logic [1:0]  AC     = lcm_pkg::LCM_ST_ACTIVE;
  logic             pclk, presetn, psel, penable, pwrite, hist, ref_validated, phase_step, err;
  logic [15:0]      paddr;
  logic [31:0]      pwdata, rd;
  logic [5:0]       vld;
  logic [17:0]      prio;
  logic [7:0]       lf;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, use_freerun_tw, discard_edge, restart_acq, refmon_reset;
  wire logic [1:0]  loop_state;
  wire logic [2:0]  active_profile;
  int               n_errors, checks_done, nd, nr, nm;

  lcm_mode_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .profile_valid(vld), .history_avail(hist),
    .ref_validated(ref_validated), .phase_step(phase_step), .loop_state(loop_state),
    .active_profile(active_profile), .use_freerun_tw(use_freerun_tw),
    .discard_edge(discard_edge), .restart_acq(restart_acq), .refmon_reset(refmon_reset));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected winner: smallest priority value, lowest index on a tie
  function automatic logic [3:0] exp_pick(input logic [5:0] v, input logic [17:0] p);
    logic [2:0] b;
    logic       f;
    b = 3'h0;
    f = 1'h0;
    for (int i = 0; i < 6; i++) begin
      if (v[i] && (!f || p[3*i+:3] < p[3*b+:3])) begin
        f = 1'h1;
        b = i[2:0];
      end
    end
    return {f, b};
  endfunction

  task automatic chk(input string nm_s, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm_s, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait wholly on pready; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic drive(input logic [5:0] v, input logic h);
    @(posedge pclk);
    vld <= v;
    hist <= h;
  endtask

  // Loop outputs follow two edges behind the inputs; four leaves margin
  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pulses(input logic step);
    if (step) begin
      @(posedge pclk); phase_step <= 1'h1;
      @(posedge pclk); phase_step <= 1'h0;
    end
    nd = 0; nr = 0; nm = 0;
    repeat (6) begin
      @(negedge pclk);
      if (discard_edge === 1'h1) nd++;
      if (restart_acq === 1'h1) nr++;
      if (refmon_reset === 1'h1) nm++;
    end
  endtask

  task automatic run_mode(input logic [1:0] md, input logic [2:0] man);
    logic [2:0] best;
    logic       fnd;
    logic [1:0] es;
    apb(1'h1, A_MODE, {24'h0, 1'h0, man, md, 2'h0});
    settle();
    {fnd, best} = exp_pick(vld, prio);
    if (md != 2'h0 && man < 3'h6 && vld[man]) begin
      es = AC;
      best = man;
    end else if (md == 2'h2) es = HO;
    else if (fnd) es = AC;
    else es = hist ? HO : FR;
    chk("loop_state", loop_state, es);
    if (es == AC) chk("active_profile", active_profile, best);
    if (es == HO) chk("use_freerun_tw", use_freerun_tw, !hist);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  // Whole sequence needs well under a thousand cycles; this allows 50000
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 16'h0000;
    pwdata = 32'h0; vld = 6'h00; hist = 1'h0; ref_validated = 1'h0; phase_step = 1'h0;
    prio = 18'h00000; lf = 8'h52; n_errors = 0; checks_done = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    settle();
    chk("reset state", loop_state, FR);
    chk("reset ftw", use_freerun_tw, 1'h1);
    apb(1'h0, A_MODE, 32'h0);
    chk("mode reset", rd, 32'h0);
    chk("no err", err, 1'h0);
    $display("test reset done");
    repeat (4) begin
      lf = lfsr(lf);
      apb(1'h1, A_MODE, {4{lf}});
      apb(1'h0, A_MODE, 32'h0);
      chk("mode readback", rd, {24'h0, lf});
    end
    apb(1'h0, 16'h0000, 32'h0);
    chk("unmapped err", err, 1'h1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'h1, A_MODE + 16'h0001, 32'hFF);
    chk("misaligned err", err, 1'h1);
    apb(1'h0, A_MODE, 32'h0);
    chk("mode kept", rd, {24'h0, lf});
    $display("test registers done");
    apb(1'h1, A_PRIO, 32'h0);
    drive(6'h2C, 1'h0); run_mode(2'h0, 3'h0);
    drive(6'h00, 1'h0); run_mode(2'h0, 3'h0);
    drive(6'h00, 1'h1); run_mode(2'h0, 3'h0);
    drive(6'h3F, 1'h0); run_mode(2'h2, 3'h6);
    repeat (24) begin
      lf = lfsr(lf); prio[7:0] = lf;
      lf = lfsr(lf); prio[15:8] = lf;
      lf = lfsr(lf); prio[17:16] = lf[1:0];
      apb(1'h1, A_PRIO, {14'h0, prio});
      lf = lfsr(lf);
      drive(lf[5:0], lf[6]);
      lf = lfsr(lf);
      run_mode((lf[1:0] == 2'h3) ? 2'h0 : lf[1:0], lf[7:5] % 3'h6);
    end
    apb(1'h0, A_PRIO, 32'h0);
    chk("prio readback", rd, {14'h0, prio});
    $display("test selection done");
    apb(1'h1, A_MODE, 32'h0C);
    drive(6'h00, 1'h0);
    for (int s = 2; s >= 0; s--) begin
      apb(1'h1, A_SW, {27'h0, 3'h4, s[1:0]});
      settle();
      chk("user state", loop_state, (s == 2) ? AC : (s == 1) ? HO : FR);
      if (s == 2) chk("user profile", active_profile, 3'h4);
    end
    $display("test user mode done");
    apb(1'h1, A_PRIO, 32'h0);
    drive(6'h3F, 1'h0);
    apb(1'h1, A_MODE, 32'h02);
    settle();
    chk("force hold", loop_state, HO);
    chk("hold no history", use_freerun_tw, 1'h1);
    drive(6'h3F, 1'h1);
    settle();
    chk("hold history", use_freerun_tw, 1'h0);
    apb(1'h1, A_MODE, 32'h01);
    settle();
    chk("force free", loop_state, FR);
    apb(1'h1, A_MODE, 32'h03);
    settle();
    chk("both forces", loop_state, FR);
    apb(1'h1, A_MODE, 32'h00);
    settle();
    chk("restored", loop_state, AC);
    chk("restored prof", active_profile, 3'h0);
    apb(1'h0, A_ST, 32'h0);
    chk("status", rd, {18'h0, 6'h3F, 1'h1, 1'h0, 1'h1, 3'h0, AC});
    $display("test force done");
    pulses(1'h1);
    chk("discard", nd, 32'h1);
    chk("restart", nr, 32'h1);
    chk("no monitor reset", nm, 32'h0);
    apb(1'h1, A_MODE, 32'h80);
    pulses(1'h1);
    chk("discard f", nd, 32'h1);
    chk("monitor reset", nm, 32'h1);
    chk("wait revalidate", nr, 32'h0);
    @(posedge pclk);
    ref_validated <= 1'h1;
    pulses(1'h0);
    chk("restart after valid", nr, 32'h1);
    @(posedge pclk);
    ref_validated <= 1'h0;
    $display("test phase step done");
    // Reset again in mid-run: registers and loop must start over
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, A_MODE, 32'h0);
    chk("mode after reset", rd, 32'h0);
    settle();
    chk("state after reset", loop_state, AC);
    chk("prof after reset", active_profile, 3'h0);
    $display("test mid reset done");
    end_sim();
  end
endmodule
`default_nettype wire
